// >>> adc_config_register_bank.sv
// Configuration register bank of the converter with its serial port and over-range detector.
//
// Notes on behaviour
// - One serial write updates every field of the addressed register at the same time.
// - Bit 15 of register 0x00 picks three-wire (shared data pin) or four-wire (separate output pin), reset 0.
// - Bit 14 of register 0x00 turns the 2x decimation filter on, reset 0.
// - Bit 12 of register 0x00 picks low or high pass and only counts while decimation is on.
// - Bit 15 of register 0x01 switches the gain and offset correction loop on, reset 0.
// - Bit 3 of register 0x01 picks two's complement (0) or offset binary (1) output, reset 0.
// - Bits 10 to 7 of register 0x02 set the over-range trip at full scale times the field over 16.
// - The over-range flag rises 12 output clocks after the input first passes the trip level.
// - After any reset the over-range field holds 15.
// - Bit 14 of register 0x03 is the correction loop restart and resets to 1.
// - While that restart bit is 1 the correction is held cleared, and writing 0 lets the loop run.
// - Writing the reset pattern to register 0x2c returns every register to reset; 0x2c reads back 0.
`timescale 1ns/10ps
module adc_config_register_bank #(
    parameter int SAMPLE_W = 12,
    parameter int TEMP_W = 9
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_sclk,
    input wire logic i_sen_n,
    input wire logic i_sdio,
    input wire logic [TEMP_W-1:0] i_temperature,
    input wire logic [SAMPLE_W-1:0] i_sample,
    input wire logic i_sample_valid,
    output logic o_sdio,
    output logic o_sdio_oe,
    output logic o_serial_output_pin,
    output logic o_serial_output_pin_oe,
    output logic o_decim_enable,
    output logic o_decim_band_select,
    output logic o_gain_offset_correction_enable,
    output logic o_performance_trim_bit,
    output logic o_correction_loop_restart,
    output logic o_correction_run,
    output logic [3:0] o_overrange_threshold,
    output logic [SAMPLE_W-1:0] o_sample_data,
    output logic o_sample_valid,
    output logic o_overrange_flag
);
    localparam int MAG_W = SAMPLE_W - 1;

    reg_access_if bus ();

    logic [15:0] bank [adc_cfg_pkg::NUM_REGS];
    logic [15:0] read_word;
    logic soft_reset;
    logic [TEMP_W-1:0] temp_meta;
    logic [TEMP_W-1:0] temp_sync;
    logic [MAG_W-1:0] magnitude;
    logic [MAG_W-1:0] trip_level;
    logic over_trip;
    logic [adc_cfg_pkg::TRIP_DELAY_CYCLES-1:0] trip_line;
    logic trip_prev;
    logic [4:0] trip_age;
    logic four_wire;
    logic decim_enable;
    logic offset_binary;
    logic [3:0] threshold;
    logic loop_restart;

    assign four_wire = bank[adc_cfg_pkg::IDX_FILTER][adc_cfg_pkg::BIT_FOUR_WIRE];
    assign decim_enable = bank[adc_cfg_pkg::IDX_FILTER][adc_cfg_pkg::BIT_DECIM_ENABLE];
    assign offset_binary = bank[adc_cfg_pkg::IDX_FORMAT][adc_cfg_pkg::BIT_DATA_FORMAT];
    assign threshold = bank[adc_cfg_pkg::IDX_THRESHOLD][adc_cfg_pkg::THRESH_MSB:adc_cfg_pkg::THRESH_LSB];
    assign loop_restart = bank[adc_cfg_pkg::IDX_LOOP][adc_cfg_pkg::BIT_LOOP_RESTART];

    // ----------------------------------------------------------------
    // Serial port
    // ----------------------------------------------------------------
    serial_port_slave port_inst (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_sclk(i_sclk),
        .i_sen_n(i_sen_n),
        .i_sdio(i_sdio),
        .i_four_wire(four_wire),
        .o_sdio(o_sdio),
        .o_sdio_oe(o_sdio_oe),
        .o_sout(o_serial_output_pin),
        .o_sout_oe(o_serial_output_pin_oe),
        .bus(bus.port)
    );

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    // The command register is never stored: matching the pattern acts at once, so it always reads 0.
    assign soft_reset = bus.wr_strobe && bus.addr == adc_cfg_pkg::ADDR_SOFT_RESET_COMMAND
        && bus.wr_data == adc_cfg_pkg::SOFT_RESET_PATTERN;

    for (genvar i = 0; i < adc_cfg_pkg::NUM_REGS; i++) begin : g_reg
        always_ff @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
                bank[i] <= adc_cfg_pkg::REG_RESET[i];
            end else if (soft_reset) begin
                bank[i] <= adc_cfg_pkg::REG_RESET[i];
            end else if (bus.wr_strobe && bus.addr == adc_cfg_pkg::REG_ADDR[i]) begin
                bank[i] <= bus.wr_data & adc_cfg_pkg::REG_MASK[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // Read-back multiplexer
    // ----------------------------------------------------------------
    always_comb begin
        read_word = 16'h0000;
        for (int i = 0; i < adc_cfg_pkg::NUM_REGS; i++) begin
            if (bus.addr == adc_cfg_pkg::REG_ADDR[i]) begin
                read_word = bank[i];
            end
        end
        if (bus.addr == adc_cfg_pkg::ADDR_POWER_BIAS_CFG) begin
            read_word = read_word | adc_cfg_pkg::POWER_BIAS_READ_ONES;
        end
        if (bus.addr == adc_cfg_pkg::ADDR_TEMPERATURE_READING) begin
            read_word = {{(16 - TEMP_W){1'b0}}, temp_sync};
        end
    end

    assign bus.rd_data = read_word;

    // The sensor word settles slowly, so a plain two-stage capture is enough here.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            temp_meta <= '0;
            temp_sync <= '0;
        end else begin
            temp_meta <= i_temperature;
            temp_sync <= temp_meta;
        end
    end

    // ----------------------------------------------------------------
    // Configuration outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_decim_enable <= 1'b0;
            o_decim_band_select <= 1'b0;
            o_gain_offset_correction_enable <= 1'b0;
            o_performance_trim_bit <= 1'b0;
            o_correction_loop_restart <= 1'b1;
            o_correction_run <= 1'b0;
            o_overrange_threshold <= adc_cfg_pkg::TRIP_THRESH_RESET;
        end else begin
            o_decim_enable <= decim_enable;
            o_decim_band_select <= decim_enable
                && bank[adc_cfg_pkg::IDX_FILTER][adc_cfg_pkg::BIT_DECIM_BAND];
            o_gain_offset_correction_enable <= bank[adc_cfg_pkg::IDX_FORMAT][adc_cfg_pkg::BIT_CORR_ENABLE];
            o_performance_trim_bit <= bank[adc_cfg_pkg::IDX_FORMAT][adc_cfg_pkg::BIT_PERF_TRIM];
            o_correction_loop_restart <= loop_restart;
            // The loop only runs once restart is cleared; while it is set the offset stays 0 and the gain 1.
            o_correction_run <= !loop_restart
                && bank[adc_cfg_pkg::IDX_FORMAT][adc_cfg_pkg::BIT_CORR_ENABLE];
            o_overrange_threshold <= threshold;
        end
    end

    // ----------------------------------------------------------------
    // Output coding
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sample_data <= '0;
            o_sample_valid <= 1'b0;
        end else begin
            o_sample_valid <= i_sample_valid;
            if (i_sample_valid) begin
                o_sample_data <= offset_binary ? {~i_sample[SAMPLE_W-1], i_sample[MAG_W-1:0]}
                    : i_sample;
            end
        end
    end

    // ----------------------------------------------------------------
    // Over-range detection
    // ----------------------------------------------------------------
    // One's complement magnitude avoids the overflow of negating the most negative code.
    assign magnitude = i_sample[SAMPLE_W-1] ? ~i_sample[MAG_W-1:0] : i_sample[MAG_W-1:0];
    assign trip_level = {threshold, {(MAG_W - 4){1'b0}}};
    assign over_trip = magnitude > trip_level;

    // Each output clock moves the delay line one step, so the flag lags the overload by a fixed count.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            trip_line <= '0;
            o_overrange_flag <= 1'b0;
        end else if (i_sample_valid) begin
            trip_line <= {trip_line[adc_cfg_pkg::TRIP_DELAY_CYCLES-2:0], over_trip};
            o_overrange_flag <= trip_line[adc_cfg_pkg::TRIP_DELAY_CYCLES-1];
        end
    end

    // Age of the latest overload in output clocks, kept apart from the delay line so its check is independent.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            trip_prev <= 1'b0;
            trip_age <= 5'h00;
        end else if (i_sample_valid) begin
            trip_prev <= over_trip;
            if (over_trip && !trip_prev) begin
                trip_age <= 5'h01;
            end else if (trip_age != 5'h00 && trip_age != 5'(adc_cfg_pkg::TRIP_DELAY_CYCLES)) begin
                trip_age <= trip_age + 5'h01;
            end else begin
                trip_age <= 5'h00;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    multi_field_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        bus.wr_strobe && bus.addr == adc_cfg_pkg::ADDR_FILTER_AND_PORT_CTRL
        |=> bank[adc_cfg_pkg::IDX_FILTER] == ($past(bus.wr_data) & adc_cfg_pkg::REG_MASK[adc_cfg_pkg::IDX_FILTER]))
        else $error("filter and port register did not take the whole word");

    decim_follow_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(decim_enable) |=> o_decim_enable ##1 o_decim_enable || !decim_enable)
        else $error("decimation enable output did not follow its bit");

    band_gate_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_decim_band_select |-> $past(decim_enable))
        else $error("band select active without decimation");

    corr_enable_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_gain_offset_correction_enable == $past(bank[adc_cfg_pkg::IDX_FORMAT][adc_cfg_pkg::BIT_CORR_ENABLE]))
        else $error("correction enable output wrong");

    format_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_sample_valid |=> o_sample_data[SAMPLE_W-1] == ($past(i_sample[SAMPLE_W-1]) ^ $past(offset_binary)))
        else $error("output coding does not match the format bit");

    trip_delay_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_sample_valid && trip_age == 5'(adc_cfg_pkg::TRIP_DELAY_CYCLES) |=> o_overrange_flag)
        else $error("over-range flag missed its fixed latency");

    trip_line_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(o_overrange_flag) |-> $past(i_sample_valid) && $past(trip_line[adc_cfg_pkg::TRIP_DELAY_CYCLES-1]))
        else $error("over-range flag rose without a matured overload");

    trip_reset_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        soft_reset |=> threshold == adc_cfg_pkg::TRIP_THRESH_RESET ##1 o_overrange_threshold == threshold)
        else $error("over-range field not restored to its reset value");

    loop_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        loop_restart |=> !o_correction_run && o_correction_loop_restart)
        else $error("correction loop ran while restart held");

    soft_clear_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        soft_reset |=> bank[adc_cfg_pkg::IDX_LOOP] == adc_cfg_pkg::REG_RESET[adc_cfg_pkg::IDX_LOOP]
        && bank[adc_cfg_pkg::IDX_FILTER] == 16'h0000)
        else $error("software reset did not restore the registers");

    fixed_zero_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        bus.addr == adc_cfg_pkg::ADDR_CORRECTION_LOOP_CTRL |-> (read_word & ~16'h4b18) == 16'h0000)
        else $error("fixed zero bit read back as one");
endmodule

// >>> adc_cfg_pkg.sv
// Register map, field positions and timing constants of the converter configuration bank.
package adc_cfg_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam int NUM_REGS = 10;
    localparam logic [6:0] ADDR_FILTER_AND_PORT_CTRL = 7'h00;
    localparam logic [6:0] ADDR_CORRECTION_FORMAT_CTRL = 7'h01;
    localparam logic [6:0] ADDR_OVERRANGE_THRESHOLD_CFG = 7'h02;
    localparam logic [6:0] ADDR_CORRECTION_LOOP_CTRL = 7'h03;
    localparam logic [6:0] ADDR_SYNC_SELECT_WIDE = 7'h0e;
    localparam logic [6:0] ADDR_SYNC_AND_REFERENCE_CFG = 7'h0f;
    localparam logic [6:0] ADDR_TEMPERATURE_READING = 7'h2b;
    localparam logic [6:0] ADDR_SOFT_RESET_COMMAND = 7'h2c;
    localparam logic [6:0] ADDR_SLEEP_MODE_CFG = 7'h37;
    localparam logic [6:0] ADDR_POWER_BIAS_CFG = 7'h38;
    localparam logic [6:0] ADDR_OUTPUT_DRIVER_CFG = 7'h3a;
    localparam logic [6:0] ADDR_OUTPUT_BUS_ENABLE = 7'h66;
    // ----------------------------------------------------------------
    // Stored registers: writable bits and reset values
    // ----------------------------------------------------------------
    localparam int IDX_FILTER = 0;
    localparam int IDX_FORMAT = 1;
    localparam int IDX_THRESHOLD = 2;
    localparam int IDX_LOOP = 3;
    localparam logic [3:0] TRIP_THRESH_RESET = 4'hf;
    localparam logic [6:0] REG_ADDR [NUM_REGS] = '{ADDR_FILTER_AND_PORT_CTRL, ADDR_CORRECTION_FORMAT_CTRL,
        ADDR_OVERRANGE_THRESHOLD_CFG, ADDR_CORRECTION_LOOP_CTRL, ADDR_SYNC_SELECT_WIDE,
        ADDR_SYNC_AND_REFERENCE_CFG, ADDR_SLEEP_MODE_CFG, ADDR_POWER_BIAS_CFG, ADDR_OUTPUT_DRIVER_CFG,
        ADDR_OUTPUT_BUS_ENABLE};
    localparam logic [15:0] REG_MASK [NUM_REGS] = '{16'hd000, 16'h800a, 16'h0780, 16'h4b18, 16'hfffc,
        16'hf070, 16'hc000, 16'hfff0, 16'hff0b, 16'hffff};
    localparam logic [15:0] REG_RESET [NUM_REGS] = '{16'h0000, 16'h0000, {5'h00, TRIP_THRESH_RESET, 7'h00},
        16'h4b18, 16'haaa8, 16'ha000, 16'h0000, 16'hfff0, 16'h0800, 16'h0000};
    localparam logic [15:0] POWER_BIAS_READ_ONES = 16'h000f;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_FOUR_WIRE = 15;
    localparam int BIT_DECIM_ENABLE = 14;
    localparam int BIT_DECIM_BAND = 12;
    localparam int BIT_CORR_ENABLE = 15;
    localparam int BIT_DATA_FORMAT = 3;
    localparam int BIT_PERF_TRIM = 1;
    localparam int BIT_LOOP_RESTART = 14;
    localparam int THRESH_LSB = 7;
    localparam int THRESH_MSB = 10;
    localparam logic [15:0] SOFT_RESET_PATTERN = 16'hd2f0;
    // ----------------------------------------------------------------
    // Serial frame and timing
    // ----------------------------------------------------------------
    localparam logic [4:0] CMD_BITS = 5'h08;
    localparam logic [4:0] FRAME_BITS = 5'h18;
    localparam int TRIP_DELAY_CYCLES = 12;
endpackage

// >>> reg_access_if.sv
// Register access signals between the serial port and the register bank.
`timescale 1ns/10ps
interface reg_access_if;
    logic wr_strobe;
    logic [6:0] addr;
    logic [15:0] wr_data;
    logic [15:0] rd_data;
    modport port (output wr_strobe, output addr, output wr_data, input rd_data);
    modport bank (input wr_strobe, input addr, input wr_data, output rd_data);
endinterface

// >>> serial_port_slave.sv
// Three- or four-wire serial port that turns frames into register writes and reads.
`timescale 1ns/10ps
module serial_port_slave (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_sclk,
    input wire logic i_sen_n,
    input wire logic i_sdio,
    input wire logic i_four_wire,
    output logic o_sdio,
    output logic o_sdio_oe,
    output logic o_sout,
    output logic o_sout_oe,
    reg_access_if.port bus
);
    logic [2:0] sclk_sync;
    logic [1:0] sen_sync;
    logic [1:0] din_sync;
    logic [4:0] bit_count;
    logic read_cmd;
    logic load_pending;
    logic reading;
    logic [15:0] shift_in;
    logic [15:0] shift_out;
    logic selected;
    logic sclk_rise;
    logic sclk_fall;
    logic din;

    // Pins are sampled by the system clock, so the serial clock must stay well below a quarter of it.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sclk_sync <= 3'h0;
            sen_sync <= 2'h3;
            din_sync <= 2'h0;
        end else begin
            sclk_sync <= {sclk_sync[1:0], i_sclk};
            sen_sync <= {sen_sync[0], i_sen_n};
            din_sync <= {din_sync[0], i_sdio};
        end
    end

    assign selected = ~sen_sync[1];
    assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
    assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
    assign din = din_sync[1];

    // ----------------------------------------------------------------
    // Frame capture
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bit_count <= 5'h00;
            read_cmd <= 1'b0;
            bus.addr <= 7'h00;
            shift_in <= 16'h0000;
        end else if (!selected) begin
            bit_count <= 5'h00;
            read_cmd <= 1'b0;
        end else if (sclk_rise && bit_count != adc_cfg_pkg::FRAME_BITS) begin
            bit_count <= bit_count + 5'h01;
            if (bit_count == 5'h00) begin
                read_cmd <= din;
            end else if (bit_count < adc_cfg_pkg::CMD_BITS) begin
                bus.addr <= {bus.addr[5:0], din};
            end else begin
                shift_in <= {shift_in[14:0], din};
            end
        end
    end

    // The whole data word lands in one strobe, so all fields of a register change together.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bus.wr_strobe <= 1'b0;
            bus.wr_data <= 16'h0000;
        end else begin
            bus.wr_strobe <= selected && sclk_rise && !read_cmd
                && bit_count == adc_cfg_pkg::FRAME_BITS - 5'h01;
            if (selected && sclk_rise && bit_count == adc_cfg_pkg::FRAME_BITS - 5'h01) begin
                bus.wr_data <= {shift_in[14:0], din};
            end
        end
    end

    // ----------------------------------------------------------------
    // Read-back
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            load_pending <= 1'b0;
            reading <= 1'b0;
            shift_out <= 16'h0000;
        end else begin
            load_pending <= selected && sclk_rise && read_cmd && bit_count == adc_cfg_pkg::CMD_BITS - 5'h01;
            if (!selected) begin
                reading <= 1'b0;
            end else if (load_pending) begin
                shift_out <= bus.rd_data;
                reading <= 1'b1;
            end else if (reading && sclk_fall) begin
                shift_out <= {shift_out[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sdio <= 1'b0;
            o_sout <= 1'b0;
            o_sdio_oe <= 1'b0;
            o_sout_oe <= 1'b0;
        end else begin
            if (reading && sclk_fall) begin
                o_sdio <= shift_out[15];
                o_sout <= shift_out[15];
            end
            o_sdio_oe <= reading && selected && !i_four_wire;
            o_sout_oe <= reading && selected && i_four_wire;
        end
    end

    port_select_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_sdio_oe |-> !$past(i_four_wire) && !o_sout_oe)
        else $error("bidirectional pin driven in four-wire mode");
    whole_word_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        bus.wr_strobe |-> $past(bit_count) == adc_cfg_pkg::FRAME_BITS - 5'h01 && !read_cmd)
        else $error("write strobe outside the last data bit");
endmodule

// >>> serial_ctrl_model.sv
// Behavioural serial controller that frames register writes and reads.
`timescale 1ns/10ps
module serial_ctrl_model (
    input wire logic i_clk,
    input wire logic i_sdio,
    input wire logic i_sdio_oe,
    input wire logic i_sout,
    input wire logic i_sout_oe,
    output logic o_sclk = 1'b0,
    output logic o_sen_n = 1'b1,
    output logic o_sdio = 1'b0,
    output logic [15:0] o_rd_data = 16'h0000,
    output logic o_rd_valid = 1'b0
);
    // The serial clock stands low between frames; the released data line toggles so stale values never pass.
    task automatic frame(input logic rd, input logic [6:0] a, input logic [15:0] d, input logic four, input int half);
        logic [23:0] bits;
        logic line;
        bits = {rd, a, d};
        @(posedge i_clk);
        o_sen_n <= 1'b0;
        for (int b = 23; b >= 0; b--) begin
            o_sdio <= (rd && b < 16) ? ~o_sdio : bits[b];
            repeat (half) @(posedge i_clk);
            line = four ? (i_sout_oe ? i_sout : 1'bx) : (i_sdio_oe ? i_sdio : 1'bx);
            if (b < 16) begin
                o_rd_data[b] <= line;
            end
            o_sclk <= 1'b1;
            repeat (half) @(posedge i_clk);
            o_sclk <= 1'b0;
        end
        repeat (half) @(posedge i_clk);
        o_sen_n <= 1'b1;
        o_sdio <= ~o_sdio;
        o_rd_valid <= rd;
        @(posedge i_clk);
        o_rd_valid <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask
endmodule

// >>> adc_config_register_bank_tb_top.sv
// Self-checking bench for the converter configuration bank.
`timescale 1ns/10ps
module adc_config_register_bank_tb_top;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [8:0] temp = 9'h000;
    logic [11:0] sample = 12'h000;
    logic [11:0] smp = 12'h000;
    logic s_in_valid = 1'b0;
    logic sclk, sen_n, ctrl_sdio, dut_sdio, sdio_oe, sout, sout_oe, rd_valid, decim, band, corr, trim, restart, run;
    logic s_valid, range_flag;
    logic [3:0] thresh;
    logic [11:0] s_data;
    logic [15:0] rd_data;
    logic [15:0] expq[$];
    logic [15:0] wdata[adc_cfg_pkg::NUM_REGS];
    int n_mismatch = 0;
    int checks_done = 0;
    int n;
    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        s_in_valid <= ~s_in_valid;
        sample <= smp;
    end
    adc_config_register_bank dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_sclk(sclk), .i_sen_n(sen_n),
        .i_sdio(sdio_oe ? dut_sdio : ctrl_sdio), .i_temperature(temp), .i_sample(sample), .i_sample_valid(s_in_valid),
        .o_sdio(dut_sdio), .o_sdio_oe(sdio_oe), .o_serial_output_pin(sout), .o_serial_output_pin_oe(sout_oe),
        .o_decim_enable(decim), .o_decim_band_select(band), .o_gain_offset_correction_enable(corr),
        .o_performance_trim_bit(trim), .o_correction_loop_restart(restart), .o_correction_run(run),
        .o_overrange_threshold(thresh), .o_sample_data(s_data), .o_sample_valid(s_valid),
        .o_overrange_flag(range_flag));
    serial_ctrl_model ctrl_u (.i_clk(i_clk), .i_sdio(dut_sdio), .i_sdio_oe(sdio_oe), .i_sout(sout),
        .i_sout_oe(sout_oe),
        .o_sclk(sclk), .o_sen_n(sen_n), .o_sdio(ctrl_sdio), .o_rd_data(rd_data), .o_rd_valid(rd_valid));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    always @(posedge i_clk) begin
        if (rd_valid === 1'b1) begin
            if (expq.size() == 0) begin
                n_mismatch++;
                $display("ERROR t=%0t got=%h exp=%h", $time, rd_data, 16'hxxxx);
            end
            else cmp(rd_data, expq.pop_front());
        end
    end
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        ctrl_u.frame(1'b0, a, d, 1'b0, 5 + $urandom % 5);
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] e, input logic four = 1'b0);
        expq.push_back(e);
        ctrl_u.frame(1'b1, a, 16'h0000, four, 5 + $urandom % 5);
    endtask
    function automatic logic [15:0] rdv(input int i, input logic [15:0] v);
        return v | ((i == 7) ? adc_cfg_pkg::POWER_BIAS_READ_ONES : 16'h0000);
    endfunction
    task automatic check_reset();
        for (int i = 0; i < adc_cfg_pkg::NUM_REGS; i++) rd(adc_cfg_pkg::REG_ADDR[i], rdv(i, adc_cfg_pkg::REG_RESET[i]));
        rd(adc_cfg_pkg::ADDR_SOFT_RESET_COMMAND, 16'h0000);
    endtask
    task automatic complete_run();
        $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // A hung handshake would otherwise stall the run forever.
    initial begin
        repeat (60000) @(posedge i_clk);
        n_mismatch++;
        complete_run();
    end
    initial begin
        void'($urandom(32'hdeb5f37b));
        temp = 9'($urandom);
        repeat (6) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        cmp({6'h00, decim, band, corr, trim, restart, run, thresh}, 16'h002f);
        check_reset();
        rd(adc_cfg_pkg::ADDR_TEMPERATURE_READING, {7'h00, temp});
        rd(7'h10, 16'h0000);
        $display("test reset_values done");
        for (int i = 0; i < adc_cfg_pkg::NUM_REGS; i++) begin
            wdata[i] = 16'($urandom) & adc_cfg_pkg::REG_MASK[i];
            if (i == adc_cfg_pkg::IDX_FILTER) wdata[i][15] = 1'b0;
            if (i == adc_cfg_pkg::IDX_LOOP) wdata[i] = wdata[i] | 16'h0b18;
            wr(adc_cfg_pkg::REG_ADDR[i], wdata[i]);
        end
        for (int i = 0; i < adc_cfg_pkg::NUM_REGS; i++) rd(adc_cfg_pkg::REG_ADDR[i], rdv(i, wdata[i]));
        wr(adc_cfg_pkg::ADDR_SOFT_RESET_COMMAND, 16'hd2f1);
        rd(adc_cfg_pkg::ADDR_OVERRANGE_THRESHOLD_CFG, wdata[2]);
        wr(adc_cfg_pkg::ADDR_SOFT_RESET_COMMAND, adc_cfg_pkg::SOFT_RESET_PATTERN);
        check_reset();
        $display("test write_and_soft_reset done");
        wr(7'h00, 16'h1000);
        cmp({15'h0000, band}, 16'h0000);
        wr(7'h00, 16'h5000);
        wr(7'h01, 16'h800a);
        wr(7'h02, 16'h0180);
        cmp({6'h00, decim, band, corr, trim, restart, run, thresh}, 16'h03e3);
        wr(7'h03, 16'h0b18);
        cmp({6'h00, decim, band, corr, trim, restart, run, thresh}, 16'h03d3);
        $display("test config_outputs done");
        @(negedge i_clk);
        smp = 12'h180;
        repeat (60) @(negedge i_clk);
        cmp({15'h0000, range_flag}, 16'h0000);
        smp = 12'h181;
        n = 0;
        while (!(s_in_valid && sample == 12'h181)) @(negedge i_clk);
        while (range_flag !== 1'b1 && n < 40) begin
            @(negedge i_clk);
            if (range_flag !== 1'b1 && s_in_valid) n++;
        end
        cmp(16'(n), 16'(adc_cfg_pkg::TRIP_DELAY_CYCLES));
        cmp({15'h0000, s_valid}, {15'h0000, ~s_in_valid});
        cmp({4'h0, s_data}, 16'h0981);
        $display("test overrange done");
        wr(7'h00, 16'h8000);
        rd(7'h00, 16'h8000, 1'b1);
        wr(7'h00, 16'h0000);
        rd(7'h00, 16'h0000);
        $display("test four_wire done");
        repeat (4) @(posedge i_clk);
        complete_run();
    end
endmodule
